// >>> hdl/wwd_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "wwd_defs.svh"
module wwd_ctrl
	import wwd_pkg::*;
(
	input  wire logic     mclk,
	input  wire logic     rst_b,
	input  wire logic     low_power_rc_oscillator_tick,
	input  wire wwd_cfg_s cfg,
	input  wire wwd_evt_s evt,
	input  wire logic     in_power_save,
	input  wire logic     sw_enable_set,
	input  wire logic     sw_enable_clr,
	input  wire logic     timeout_flag_clr,
	output logic          software_enable_bit,
	output logic          timeout_flag,
	output logic          wdt_running,
	output logic          device_reset_req,
	output logic          wake_req
);
	logic                   tick_s1_ff, tick_s2_ff, tick_s3_ff;
	logic [7:0]             pre_ff, nxt_pre;
	logic [`WWD_CNT_W-1:0]  post_ff, nxt_post;
	logic                   swen_ff, nxt_swen;
	logic                   flag_ff, nxt_flag;
	logic                   rst_req_ff, nxt_rst_req;
	logic                   wake_ff, nxt_wake;
	logic                   tick_rise, pre_wrap, post_wrap, run, restart;
	logic                   early_clr, expire;
	logic [7:0]             pre_max;
	logic [`WWD_CNT_W-1:0]  post_max, win_open;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tick_s1_ff <= 1'b0;
			tick_s2_ff <= 1'b0;
			tick_s3_ff <= 1'b0;
		end else begin
			tick_s1_ff <= low_power_rc_oscillator_tick;
			tick_s2_ff <= tick_s1_ff;
			tick_s3_ff <= tick_s2_ff;
		end
	end

	always_comb begin
		tick_rise = tick_s2_ff & ~tick_s3_ff;
		run = cfg.hw_enable_fuse | swen_ff;
		pre_max = cfg.prescale_select_fuse ? `WWD_PRE_LONG
			: `WWD_PRE_SHORT;
		post_max = (`WWD_CNT_W'(1) << cfg.postscale_select_field)
			- `WWD_CNT_W'(1);
		// window opens at max minus select quarters of max (post_max >> 2)
		win_open = post_max - (post_max >> 2) * `WWD_CNT_W'(
			{13'h0000, cfg.window_select_field});
		pre_wrap = tick_rise & (pre_ff == pre_max);
		post_wrap = pre_wrap & (post_ff == post_max);
		early_clr = run & evt.clear_watchdog_instruction
			& ~cfg.window_disable_bit & (post_ff < win_open);
		restart = evt.clear_watchdog_instruction
			| evt.power_save_instruction | evt.power_save_exit
			| evt.clock_switch_done | ~run;
		expire = run & post_wrap & ~restart;
		nxt_pre = pre_ff;
		nxt_post = post_ff;
		if (restart) begin
			nxt_pre = 8'h00;
			nxt_post = '0;
		end else if (tick_rise) begin
			nxt_pre = pre_wrap ? 8'h00 : pre_ff + 8'h01;
			if (pre_wrap)
				nxt_post = post_wrap ? '0 : post_ff + `WWD_CNT_W'(1);
		end
		nxt_swen = swen_ff;
		if (sw_enable_set)
			nxt_swen = 1'b1;
		else if (sw_enable_clr)
			nxt_swen = 1'b0;
		// set wins over the software clear
		nxt_flag = (expire | early_clr) | (flag_ff & ~timeout_flag_clr);
		nxt_rst_req = early_clr | (expire & ~in_power_save);
		nxt_wake = expire & in_power_save;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pre_ff <= 8'h00;
			post_ff <= '0;
			swen_ff <= 1'b0;
			flag_ff <= 1'b0;
			rst_req_ff <= 1'b0;
			wake_ff <= 1'b0;
		end else begin
			pre_ff <= nxt_pre;
			post_ff <= nxt_post;
			swen_ff <= nxt_swen;
			flag_ff <= nxt_flag;
			rst_req_ff <= nxt_rst_req;
			wake_ff <= nxt_wake;
		end
	end

	assign software_enable_bit = swen_ff;
	assign timeout_flag = flag_ff;
	assign wdt_running = run;
	assign device_reset_req = rst_req_ff;
	assign wake_req = wake_ff;

	AST_FUSE_RUN: assert property (@(posedge mclk) disable iff (!rst_b)
		cfg.hw_enable_fuse |-> wdt_running)
		else $error("fuse set but watchdog idle");
	AST_SW_RUN: assert property (@(posedge mclk) disable iff (!rst_b)
		!cfg.hw_enable_fuse |-> (wdt_running == software_enable_bit))
		else $error("software enable not followed");
	AST_FLAG_STICKY: assert property (@(posedge mclk) disable iff (!rst_b)
		timeout_flag && !timeout_flag_clr |=> timeout_flag)
		else $error("flag dropped without clear");
	AST_FLAG_SET: assert property (@(posedge mclk) disable iff (!rst_b)
		expire |=> timeout_flag)
		else $error("timeout did not set flag");
	AST_EARLY: assert property (@(posedge mclk) disable iff (!rst_b)
		early_clr |=> device_reset_req && timeout_flag)
		else $error("early clear not punished");
	AST_NOWIN: assert property (@(posedge mclk) disable iff (!rst_b)
		cfg.window_disable_bit |-> !early_clr)
		else $error("window check in plain mode");
	AST_RESTART: assert property (@(posedge mclk) disable iff (!rst_b)
		evt.clear_watchdog_instruction |=> pre_ff == 8'h00 && post_ff == '0)
		else $error("counters not restarted");
	AST_SLEEP_WAKE: assert property (@(posedge mclk) disable iff (!rst_b)
		expire && in_power_save |=> wake_req && !device_reset_req)
		else $error("sleep timeout reset the device");
	AST_RST_PULSE: assert property (@(posedge mclk) disable iff (!rst_b)
		device_reset_req && !(expire || early_clr) |=> !device_reset_req)
		else $error("reset request longer than one cycle");
	AST_WAKE_PULSE: assert property (@(posedge mclk) disable iff (!rst_b)
		wake_req && !expire |=> !wake_req)
		else $error("wake request longer than one cycle");
	AST_PRE: assert property (@(posedge mclk) disable iff (!rst_b)
		pre_ff <= pre_max || $changed(cfg.prescale_select_fuse))
		else $error("prescaler beyond its limit");
endmodule
`default_nettype wire

// >>> pkg/wwd_defs.svh
// Notes on behaviour
// - fuse set keeps watchdog always running
// - fuse clear: software bit enables watchdog
// - any device reset clears software enable
// - timeout sets flag; only software or reset clears it
// - window disable bit zero selects windowed mode
// - 32 kHz tick, prescale by 32 or 128
// - 4-bit postscale select, 1:1 to 1:32768
// - counters reset on reset, switch, power-save, clear
// - timeout in sleep/idle wakes instead of resetting
`ifndef WWD_DEFS_SVH
`define WWD_DEFS_SVH
`define WWD_PRE_SHORT 8'h1F
`define WWD_PRE_LONG 8'h7F
`define WWD_POST_W 4
`define WWD_WIN_W 2
`define WWD_CNT_W 15
`endif

// >>> pkg/wwd_pkg.sv
`include "wwd_defs.svh"
package wwd_pkg;
	typedef struct packed {
		logic                   hw_enable_fuse;
		logic                   window_disable_bit;
		logic [`WWD_WIN_W-1:0]  window_select_field;
		logic                   prescale_select_fuse;
		logic [`WWD_POST_W-1:0] postscale_select_field;
	} wwd_cfg_s;
	typedef struct packed {
		logic clear_watchdog_instruction;
		logic power_save_instruction;
		logic power_save_exit;
		logic clock_switch_done;
	} wwd_evt_s;
endpackage

// >>> testbench/test_wwd_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_wwd_ctrl import wwd_pkg::*; ;
	logic     mclk = 0, rst_b = 0, tick = 0, ps = 0;
	logic     sw_set = 0, sw_clr = 0, fclr = 0;
	logic     swen, flag, run, rreq, wreq;
	logic [7:0] lf = 8'h20;
	wwd_cfg_s cfg = '0;
	wwd_evt_s evt = '0;
	int       fail_count = 0, checks = 0, nres = 0, nwak = 0;
	wwd_ctrl i_dut (.mclk(mclk), .rst_b(rst_b), .low_power_rc_oscillator_tick(tick), .cfg(cfg),
		.evt(evt), .in_power_save(ps), .sw_enable_set(sw_set),
		.sw_enable_clr(sw_clr), .timeout_flag_clr(fclr),
		.software_enable_bit(swen), .timeout_flag(flag), .wdt_running(run),
		.device_reset_req(rreq), .wake_req(wreq));
	initial forever #50 mclk = ~mclk;
	always @(posedge mclk) begin
		if (rreq === 1'h1) nres++;
		if (wreq === 1'h1) nwak++;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		if (fail_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// one clear pulse, then n oscillator ticks of four mclk cycles each, with another clear pulse after every cl-th tick when cl is nonzero
	task automatic go(input int n, input int cl, input int er, input int ew);
		nres = 0;
		nwak = 0;
		@(posedge mclk) evt.clear_watchdog_instruction <= 1'h1;
		@(posedge mclk) evt.clear_watchdog_instruction <= 1'h0;
		for (int i = 1; i <= n; i++) begin
			repeat (2) @(posedge mclk) tick <= 1'h1;
			repeat (2) @(posedge mclk) tick <= 1'h0;
			if (cl != 0 && i % cl == 0) begin
				@(posedge mclk) evt.clear_watchdog_instruction <= 1'h1;
				@(posedge mclk) evt.clear_watchdog_instruction <= 1'h0;
			end
		end
		repeat (8) @(posedge mclk);
		chk(nres, er);
		chk(nwak, ew);
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		end_sim;
	end
	initial begin
		cfg.window_disable_bit = 1'h1;
		repeat (16) @(posedge mclk);
		rst_b <= 1'h1;
		lf = lfsr(lf);
		@(posedge mclk) cfg.hw_enable_fuse <= lf[0];
		@(posedge mclk);
		chk(swen, 1'h0);
		chk(run, lf[0]);
		cfg.hw_enable_fuse <= 1'h0;
		sw_set <= 1'h1;
		@(posedge mclk) sw_set <= 1'h0;
		@(posedge mclk) chk(run, 1'h1);
		sw_clr <= 1'h1;
		@(posedge mclk) sw_clr <= 1'h0;
		@(posedge mclk) chk(run, 1'h0);
		go(40, 0, 0, 0);
		cfg.hw_enable_fuse <= 1'h1;
		go(40, 0, 1, 0);
		repeat (20) @(posedge mclk);
		chk(flag, 1'h1);
		fclr <= 1'h1;
		@(posedge mclk) fclr <= 1'h0;
		@(posedge mclk) chk(flag, 1'h0);
		go(40, 8, 0, 0);
		ps <= 1'h1;
		go(40, 0, 0, 1);
		ps <= 1'h0;
		cfg.prescale_select_fuse <= 1'h1;
		go(130, 0, 1, 0);
		cfg.prescale_select_fuse <= 1'h0;
		cfg.postscale_select_field <= 4'h3;
		cfg.window_select_field <= 2'h3;
		go(260, 0, 1, 0);
		cfg.window_disable_bit <= 1'h0;
		go(0, 0, 1, 0);
		go(330, 160, 1, 0);
		end_sim;
	end
endmodule
`default_nettype wire
